// ==== rtl/pio_line_defs.svh ====
// Register offsets, reset values and layout constants of the line controller
`ifndef PIO_LINE_DEFS_SVH
`define PIO_LINE_DEFS_SVH
`define LINE_COUNT            32
`define OFF_OWN_CLAIM         8'h00
`define OFF_OWN_RELEASE       8'h04
`define OFF_OWN_STATE         8'h08
`define OFF_DRV_SET           8'h10
`define OFF_DRV_CLEAR         8'h14
`define OFF_DRV_STATE         8'h18
`define OFF_DGL_SET           8'h20
`define OFF_DGL_CLEAR         8'h24
`define OFF_DGL_STATE         8'h28
`define OFF_LVL_SET           8'h30
`define OFF_LVL_CLEAR         8'h34
`define OFF_LVL_STATE         8'h38
`define OFF_PIN_STATE         8'h3C
`define OFF_IRQ_EN_SET        8'h40
`define OFF_IRQ_EN_CLEAR      8'h44
`define OFF_IRQ_MASK          8'h48
`define OFF_CHANGE_FLAGS      8'h4C
`define OFF_FN_ONE_SEL        8'h70
`define OFF_FN_TWO_SEL        8'h74
`define OFF_FN_STATE          8'h78
`define OFF_GATE_SET          8'hA0
`define OFF_GATE_CLEAR        8'hA4
`define OFF_GATE_STATE        8'hA8
`define RST_ZERO              32'h0000_0000
`define AXI_RESP_OKAY         2'b00
`define AXI_RESP_SLVERR       2'b10
`endif

// ==== rtl/pio_line_pkg.sv ====
// Types shared by the line controller files
package pio_line_pkg;
   typedef struct packed {
      logic [7:0]  addr;
      logic [31:0] data;
   } reg_write_t;
   typedef struct packed {
      logic [31:0] own;
      logic [31:0] drv;
      logic [31:0] dgl;
      logic [31:0] lvl;
      logic [31:0] fn;
   } line_cfg_t;
   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,
      WR_DO   = 3'b010,
      WR_RESP = 3'b100
   } wr_state_t;
endpackage

// ==== rtl/pin_sync.sv ====
// Two-flop synchroniser for the pin levels
`timescale 1ns/1ps
module pin_sync
   import pio_line_pkg::*;
(
   input  wire logic        aclk,     // System clock
   input  wire logic        aresetn,  // Sync reset, low
   input  wire logic [31:0] async_in, // Raw pin levels
   output logic      [31:0] sync_out  // Synchronised levels
);
   logic [31:0] meta_reg;
   // First stage only feeds the second; no reset, so the levels track the
   // pads through reset and no false change follows its release
   always_ff @(posedge aclk) begin
      meta_reg <= async_in;
      sync_out <= meta_reg; // R12
   end
endmodule // pin_sync

// ==== rtl/change_detect.sv ====
// Per-line input change flags, cleared as a whole on read
`timescale 1ns/1ps
module change_detect
   import pio_line_pkg::*;
(
   input  wire logic        aclk,      // System clock
   input  wire logic        aresetn,   // Sync reset, low
   input  wire logic [31:0] level,     // Synchronised level
   input  wire logic        read_clr,  // Flags read this cycle
   input  wire logic [31:0] impl_mask, // Implemented lines
   output logic      [31:0] flags      // Sticky change flags
);
   logic [31:0] prev_reg;
   logic        primed_reg;
   // Compare successive samples; a change in the read cycle survives
   genvar i;
   generate
      for (i = 0; i < 32; i++) begin : g_line
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               flags[i] <= 1'b0;
            end else if (primed_reg && impl_mask[i] && (level[i] != prev_reg[i])) begin
               flags[i] <= 1'b1;
            end else if (read_clr) begin
               flags[i] <= 1'b0;
            end
         end
      end
   endgenerate
   // Previous sample; first one after reset is not a change
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg   <= 32'h0000_0000;
         primed_reg <= 1'b0;
      end else begin
         prev_reg   <= level;
         primed_reg <= 1'b1;
      end
   end
endmodule // change_detect

// ==== rtl/pio_line_ctrl.sv ====
// AXI4-Lite parallel I/O line controller, per-line set/clear control
//
// Design decisions made here: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`include "pio_line_defs.svh"
// Function
// R1: Claim write one gives controller the line
// R2: Release write one hands line to peripheral
// R3: Ownership state reads one when controller owns
// R4: Ownership reset value is a parameter
// R5: Driver set write one enables output
// R6: Driver clear write one disables output
// R7: Driver state reads one when output enabled
// R8: Deglitch set write one enables filter
// R9: Deglitch clear write one disables filter
// R10: Deglitch state reads filter enables
// R11: Level state directly writable only where gated
// R12: Pin level state shows sampled levels
// R13: Change flags reset zero, still capture changes
// R14: Function select pair has inverted polarity
// R15: Unimplemented lines ignore writes, read zero
// R16: Reading change flags clears them all
// R17: Level set write one drives one
// R18: Status updated before next bus access
module pio_line_ctrl
   import pio_line_pkg::*;
#(
   parameter logic [31:0] OWN_RESET = 32'hFFFF_FFFF, // Product-specific ownership reset
   parameter logic [31:0] IMPL_MASK = 32'hFFFF_FFFF  // Implemented lines
)(
   input  wire logic        aclk,          // System clock
   input  wire logic        aresetn,       // Sync reset, low
   input  wire logic [7:0]  s_axi_awaddr,  // Write address
   input  wire logic        s_axi_awvalid, // Write address valid
   output logic             s_axi_awready, // Write address ready
   input  wire logic [31:0] s_axi_wdata,   // Write data
   input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
   input  wire logic        s_axi_wvalid,  // Write data valid
   output logic             s_axi_wready,  // Write data ready
   output logic [1:0]       s_axi_bresp,   // Write response
   output logic             s_axi_bvalid,  // Write response valid
   input  wire logic        s_axi_bready,  // Write response ready
   input  wire logic [7:0]  s_axi_araddr,  // Read address
   input  wire logic        s_axi_arvalid, // Read address valid
   output logic             s_axi_arready, // Read address ready
   output logic [31:0]      s_axi_rdata,   // Read data
   output logic [1:0]       s_axi_rresp,   // Read response
   output logic             s_axi_rvalid,  // Read response valid
   input  wire logic        s_axi_rready,  // Read response ready
   input  wire logic [31:0] pin_in,        // Pin levels, async
   output logic [31:0]      ctrl_own,      // Controller owns line
   output logic [31:0]      drv_en,        // Output driver enable
   output logic [31:0]      pin_out,       // Level to drive
   output logic [31:0]      pin_oe_n,      // Pad enable, low drives
   output logic [31:0]      dgl_en,        // Glitch filter enable
   output logic [31:0]      fn_two,        // Peripheral two selected
   output logic             irq            // Change interrupt level
);
   logic [31:0] own_reg, drv_reg, dgl_reg, lvl_reg, fn_reg, gate_reg, mask_reg;
   logic [31:0] pin_sync_lvl, chg_flags;
   logic [7:0]  aw_addr_reg;
   logic [31:0] w_data_reg;
   logic        aw_have_reg, w_have_reg, rd_clr;
   wr_state_t   wr_state_reg;
   logic [31:0] wd;
   logic [31:0] rd_next;
   logic        rd_hit;
   line_cfg_t   cfg;

   // Two-flop sampling of the pins
   pin_sync u_sync (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .async_in (pin_in),
      .sync_out (pin_sync_lvl)
   );

   // Change flags; pending changes are cleared when read
   change_detect u_chg (
      .aclk      (aclk),
      .aresetn   (aresetn),
      .level     (pin_sync_lvl),
      .read_clr  (rd_clr),
      .impl_mask (IMPL_MASK),
      .flags     (chg_flags)
   );

   // Write address and data taken in either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
         aw_addr_reg <= 8'h00;
         w_data_reg  <= 32'h0000_0000;
      end else if (wr_state_reg == WR_DO) begin
         aw_have_reg <= 1'b0;
         w_have_reg  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
         end
      end
   end

   // Ready only while the slot is empty and no write is in flight
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
      end else begin
         s_axi_awready <= (wr_state_reg == WR_IDLE) && !aw_have_reg &&
                          !(s_axi_awvalid && s_axi_awready);
         s_axi_wready  <= (wr_state_reg == WR_IDLE) && !w_have_reg &&
                          !(s_axi_wvalid && s_axi_wready);
      end
   end

   // Write sequencer: collect, apply, respond
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state_reg <= WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `AXI_RESP_OKAY;
      end else begin
         case (wr_state_reg)
            WR_IDLE: begin
               if (aw_have_reg && w_have_reg) begin
                  wr_state_reg <= WR_DO;
               end
            end
            WR_DO: begin
               wr_state_reg <= WR_RESP;
               s_axi_bvalid <= 1'b1;
               s_axi_bresp  <= `AXI_RESP_OKAY;
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wr_state_reg <= WR_IDLE;
               end
            end
            default: wr_state_reg <= WR_IDLE;
         endcase
      end
   end

   // Only implemented lines take effect; strobes ignored, whole-word registers
   assign wd = w_data_reg & IMPL_MASK; // R15

   // Ownership pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         own_reg <= OWN_RESET & IMPL_MASK; // R4
      end else if (wr_state_reg == WR_DO) begin
         if (aw_addr_reg == `OFF_OWN_CLAIM) begin
            own_reg <= own_reg | wd; // R1
         end else if (aw_addr_reg == `OFF_OWN_RELEASE) begin
            own_reg <= own_reg & ~wd; // R2
         end
      end
   end

   // Driver enable pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         drv_reg <= `RST_ZERO;
      end else if (wr_state_reg == WR_DO) begin
         if (aw_addr_reg == `OFF_DRV_SET) begin
            drv_reg <= drv_reg | wd; // R5
         end else if (aw_addr_reg == `OFF_DRV_CLEAR) begin
            drv_reg <= drv_reg & ~wd; // R6
         end
      end
   end

   // Deglitch enable pair
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dgl_reg <= `RST_ZERO;
      end else if (wr_state_reg == WR_DO) begin
         if (aw_addr_reg == `OFF_DGL_SET) begin
            dgl_reg <= dgl_reg | wd; // R8
         end else if (aw_addr_reg == `OFF_DGL_CLEAR) begin
            dgl_reg <= dgl_reg & ~wd; // R9
         end
      end
   end

   // Drive level: set, clear, or gated direct write
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lvl_reg <= `RST_ZERO;
      end else if (wr_state_reg == WR_DO) begin
         if (aw_addr_reg == `OFF_LVL_SET) begin
            lvl_reg <= lvl_reg | wd; // R17
         end else if (aw_addr_reg == `OFF_LVL_CLEAR) begin
            lvl_reg <= lvl_reg & ~wd;
         end else if (aw_addr_reg == `OFF_LVL_STATE) begin
            lvl_reg <= (lvl_reg & ~gate_reg) | (wd & gate_reg); // R11
         end
      end
   end

   // Direct-write gate and interrupt mask pairs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gate_reg <= `RST_ZERO;
         mask_reg <= `RST_ZERO;
      end else if (wr_state_reg == WR_DO) begin
         if (aw_addr_reg == `OFF_GATE_SET) begin
            gate_reg <= gate_reg | wd;
         end else if (aw_addr_reg == `OFF_GATE_CLEAR) begin
            gate_reg <= gate_reg & ~wd;
         end else if (aw_addr_reg == `OFF_IRQ_EN_SET) begin
            mask_reg <= mask_reg | wd;
         end else if (aw_addr_reg == `OFF_IRQ_EN_CLEAR) begin
            mask_reg <= mask_reg & ~wd;
         end
      end
   end

   // Function select: first register clears, second sets
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fn_reg <= `RST_ZERO;
      end else if (wr_state_reg == WR_DO) begin
         if (aw_addr_reg == `OFF_FN_ONE_SEL) begin
            fn_reg <= fn_reg & ~wd; // R14
         end else if (aw_addr_reg == `OFF_FN_TWO_SEL) begin
            fn_reg <= fn_reg | wd; // R14
         end
      end
   end

   assign cfg = '{own: own_reg, drv: drv_reg, dgl: dgl_reg, lvl: lvl_reg, fn: fn_reg};

   // Read mux; status registers read live values
   always_comb begin
      rd_hit  = 1'b1;
      rd_next = 32'h0000_0000;
      case (s_axi_araddr)
         `OFF_OWN_STATE:    rd_next = cfg.own; // R3
         `OFF_DRV_STATE:    rd_next = cfg.drv; // R7
         `OFF_DGL_STATE:    rd_next = cfg.dgl; // R10
         `OFF_LVL_STATE:    rd_next = cfg.lvl;
         `OFF_PIN_STATE:    rd_next = pin_sync_lvl & IMPL_MASK; // R12
         `OFF_IRQ_MASK:     rd_next = mask_reg;
         `OFF_CHANGE_FLAGS: rd_next = chg_flags; // R13
         `OFF_FN_STATE:     rd_next = cfg.fn;
         `OFF_GATE_STATE:   rd_next = gate_reg;
         `OFF_OWN_CLAIM, `OFF_OWN_RELEASE, `OFF_DRV_SET, `OFF_DRV_CLEAR,
         `OFF_DGL_SET, `OFF_DGL_CLEAR, `OFF_LVL_SET, `OFF_LVL_CLEAR,
         `OFF_IRQ_EN_SET, `OFF_IRQ_EN_CLEAR, `OFF_FN_ONE_SEL, `OFF_FN_TWO_SEL,
         `OFF_GATE_SET, `OFF_GATE_CLEAR: rd_next = 32'h0000_0000;
         default:           rd_hit  = 1'b0;
      endcase
   end

   // Read flags clear in the cycle the address is taken
   assign rd_clr = s_axi_arvalid && s_axi_arready &&
                   (s_axi_araddr == `OFF_CHANGE_FLAGS); // R16

   // Read channel, one outstanding; data captured with the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `AXI_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_next;
         s_axi_rresp   <= rd_hit ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
      end else if (s_axi_rvalid) begin
         if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end else begin
         s_axi_arready <= (wr_state_reg != WR_DO); // R18
      end
   end

   // Line outputs registered from the control state
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl_own <= 32'h0000_0000;
         drv_en   <= 32'h0000_0000;
         pin_out  <= 32'h0000_0000;
         pin_oe_n <= 32'hFFFF_FFFF;
         dgl_en   <= 32'h0000_0000;
         fn_two   <= 32'h0000_0000;
         irq      <= 1'b0;
      end else begin
         ctrl_own <= own_reg;
         drv_en   <= drv_reg;
         pin_out  <= lvl_reg;
         pin_oe_n <= ~(drv_reg & own_reg);
         dgl_en   <= dgl_reg;
         fn_two   <= fn_reg;
         irq      <= |(chg_flags & mask_reg);
      end
   end

   // Effect of claim, release, driver set/clear, deglitch set and function-one writes, unimplemented lines and interrupt level
   sequence s_claim;
      (wr_state_reg == WR_DO) && (aw_addr_reg == `OFF_OWN_CLAIM);
   endsequence
   a_own_claim: assert property (@(posedge aclk) disable iff (!aresetn)
      s_claim |=> ((own_reg & wd) == ($past(wd)))) // R1
      else $error("claim did not set ownership");
   a_own_release: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_state_reg == WR_DO) && (aw_addr_reg == `OFF_OWN_RELEASE)
      |=> ((own_reg & $past(wd)) == 32'h0000_0000)) // R2
      else $error("release did not clear ownership");
   a_drv_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_state_reg == WR_DO) && (aw_addr_reg == `OFF_DRV_SET)
      |=> ((drv_reg & $past(wd)) == $past(wd))) // R5
      else $error("driver set failed");
   a_drv_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_state_reg == WR_DO) && (aw_addr_reg == `OFF_DRV_CLEAR)
      |=> ((drv_reg & $past(wd)) == 32'h0000_0000)) // R6
      else $error("driver clear failed");
   a_dgl_set: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_state_reg == WR_DO) && (aw_addr_reg == `OFF_DGL_SET)
      |=> ((dgl_reg & $past(wd)) == $past(wd))) // R8
      else $error("deglitch set failed");
   a_fn_invert: assert property (@(posedge aclk) disable iff (!aresetn)
      (wr_state_reg == WR_DO) && (aw_addr_reg == `OFF_FN_ONE_SEL)
      |=> ((fn_reg & $past(wd)) == 32'h0000_0000)) // R14
      else $error("function one select did not clear");
   a_unimpl_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      ((own_reg | drv_reg | dgl_reg) & ~IMPL_MASK) == 32'h0000_0000) // R15
      else $error("unimplemented line bit set");
   a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
      (|(chg_flags & mask_reg)) |=> irq)
      else $error("interrupt not raised");
endmodule // pio_line_ctrl

// ==== dv/pin_partner.sv ====
// Model of the pads and the outside world seen by the line controller
`timescale 1ns/1ps
module pin_partner (
   input  wire logic [31:0] ext_level, // Level the outside world applies
   input  wire logic [31:0] pin_out,   // Level the controller drives
   input  wire logic [31:0] pin_oe_n,  // Pad enable, low drives
   output logic      [31:0] pin_in     // Level seen at the pads
);
   // A driven pad shows the controller level; the outside world loses the fight
   always_comb begin
      for (int i = 0; i < 32; i++) begin
         pin_in[i] = pin_oe_n[i] ? ext_level[i] : pin_out[i];
      end
   end
endmodule // pin_partner

// ==== dv/testbench.sv ====
// Self-checking bench for the AXI4-Lite parallel line controller
`timescale 1ns/1ps
`include "pio_line_defs.svh"
module testbench;
   import pio_line_pkg::*;
   // Upper byte left unimplemented so masking is exercised
   localparam logic [31:0] OWN_RST = 32'h0000_FFFF;
   localparam logic [31:0] IMPL    = 32'h00FF_FFFF;
   typedef struct {
      logic [7:0]  wa;
      logic [31:0] wd;
      logic [7:0]  ra;
      logic [31:0] exp;
   } row_t;
   logic        aclk, aresetn;
   logic [7:0]  awaddr, araddr;
   logic        awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, irq;
   logic [31:0] wdata, rdata, pin_in, ext_level, ctrl_own, drv_en, pin_out;
   logic [31:0] pin_oe_n, dgl_en, fn_two, rd;
   logic [1:0]  bresp, rresp, rr;
   int          errors, n_compared, cyc;
   row_t        rows [12];
   pio_line_ctrl #(.OWN_RESET(OWN_RST), .IMPL_MASK(IMPL)) i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
      .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in),
      .ctrl_own(ctrl_own), .drv_en(drv_en), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .dgl_en(dgl_en), .fn_two(fn_two), .irq(irq));
   pin_partner i_pins (.ext_level(ext_level), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
      .pin_in(pin_in));
   // Clock, 10 ns period
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // Hang guard, far above the few hundred cycles the tests need
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // One AXI write; address and data released each on its own handshake
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
      bit aw_done, w_done;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_done = 0;
      w_done = 0;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (!aw_done && awready) begin
            aw_done = 1;
            awvalid <= 1'b0;
         end
         if (!w_done && wready) begin
            w_done = 1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 1'b0;
      check("bresp", {30'h0, bresp}, {30'h0, `AXI_RESP_OKAY});
   endtask
   // One AXI read; data and response taken at the rvalid edge
   task automatic axi_rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge aclk); while (!arready);
      arvalid <= 1'b0;
      do @(posedge aclk); while (!rvalid);
      rd = rdata;
      rr = rresp;
      rready <= 1'b0;
   endtask
   task automatic finish_test();
      $display("Compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      aresetn = 1'b0;
      {awaddr, araddr, wdata} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      ext_level = 32'h0000_0000;
      rows = '{
         '{`OFF_OWN_CLAIM,   32'hFFFF_0000, `OFF_OWN_STATE, 32'h00FF_FFFF},
         '{`OFF_OWN_RELEASE, 32'h0000_00F0, `OFF_OWN_STATE, 32'h00FF_FF0F},
         '{`OFF_DRV_SET,     32'hFF00_00FF, `OFF_DRV_STATE, 32'h0000_00FF},
         '{`OFF_DRV_CLEAR,   32'h0000_000F, `OFF_DRV_STATE, 32'h0000_00F0},
         '{`OFF_DGL_SET,     32'h0000_0F00, `OFF_DGL_STATE, 32'h0000_0F00},
         '{`OFF_DGL_CLEAR,   32'h0000_0100, `OFF_DGL_STATE, 32'h0000_0E00},
         '{`OFF_LVL_SET,     32'h0000_0030, `OFF_LVL_STATE, 32'h0000_0030},
         '{`OFF_FN_TWO_SEL,  32'h0000_0F00, `OFF_FN_STATE,  32'h0000_0F00},
         '{`OFF_FN_ONE_SEL,  32'h0000_0300, `OFF_FN_STATE,  32'h0000_0C00},
         '{`OFF_LVL_STATE,   32'hFFFF_FFFF, `OFF_LVL_STATE, 32'h0000_0030},
         '{`OFF_GATE_SET,    32'h0000_000F, `OFF_GATE_STATE, 32'h0000_000F},
         '{`OFF_LVL_STATE,   32'h0000_0005, `OFF_LVL_STATE, 32'h0000_0035}};
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values through the bus, pad enable at its port
      axi_rd(`OFF_OWN_STATE);
      check("own reset", rd, OWN_RST);
      axi_rd(`OFF_DRV_STATE);
      check("drv reset", rd, `RST_ZERO);
      axi_rd(`OFF_CHANGE_FLAGS);
      check("flags reset", rd, `RST_ZERO);
      check("oe_n reset", pin_oe_n, 32'hFFFF_FFFF);
      $display("Test reset done");
      // Set/clear pairs and gated direct writes, each read back on the very next access
      foreach (rows[i]) begin
         axi_wr(rows[i].wa, rows[i].wd);
         axi_rd(rows[i].ra);
         check("row readback", rd, rows[i].exp);
         check("row rresp", {30'h0, rr}, {30'h0, `AXI_RESP_OKAY});
      end
      check("ctrl_own port", ctrl_own, 32'h00FF_FF0F);
      check("drv_en port", drv_en, 32'h0000_00F0);
      check("dgl_en port", dgl_en, 32'h0000_0E00);
      check("fn_two port", fn_two, 32'h0000_0C00);
      check("pin_out port", pin_out, 32'h0000_0035);
      $display("Test set/clear table done");
      // Drive line 0 high while the world pulls other lines
      axi_wr(`OFF_DRV_SET, 32'h0000_0001);
      // Pad enable follows the register one edge later; look once settled
      @(negedge aclk);
      check("oe_n line0", pin_oe_n, 32'hFFFF_FFFE);
      @(posedge aclk);
      ext_level <= 32'h0100_A5A4;
      repeat (8) @(posedge aclk);
      axi_rd(`OFF_PIN_STATE);
      check("pin level", rd, 32'h0000_A5A5);
      axi_rd(`OFF_CHANGE_FLAGS);
      check("flags set", rd, 32'h0000_A5A5);
      axi_rd(`OFF_CHANGE_FLAGS);
      check("flags cleared", rd, `RST_ZERO);
      $display("Test pins and flags done");
      // Interrupt raised, cleared by read, then masked
      axi_wr(`OFF_IRQ_EN_SET, 32'h0000_0100);
      axi_rd(`OFF_IRQ_MASK);
      check("irq mask", rd, 32'h0000_0100);
      ext_level <= 32'h0100_A4A4;
      repeat (8) @(posedge aclk);
      check("irq raised", {31'h0, irq}, 32'h0000_0001);
      axi_rd(`OFF_CHANGE_FLAGS);
      check("irq flag", rd, 32'h0000_0100);
      repeat (3) @(posedge aclk);
      check("irq cleared", {31'h0, irq}, 32'h0000_0000);
      axi_wr(`OFF_IRQ_EN_CLEAR, 32'h0000_0100);
      ext_level <= 32'h0100_A5A4;
      repeat (8) @(posedge aclk);
      check("irq masked", {31'h0, irq}, 32'h0000_0000);
      $display("Test interrupt done");
      // Write-only and unmapped reads
      axi_rd(`OFF_OWN_CLAIM);
      check("wo read", rd, `RST_ZERO);
      check("wo rresp", {30'h0, rr}, {30'h0, `AXI_RESP_OKAY});
      axi_rd(8'h0C);
      check("unmapped rdata", rd, `RST_ZERO);
      check("unmapped rresp", {30'h0, rr}, {30'h0, `AXI_RESP_SLVERR});
      $display("Test access kinds done");
      // Reset in mid-run; line 0 loses its driver and falls to the outside level
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (5) @(posedge aclk);
      check("drv_en after reset", drv_en, `RST_ZERO);
      axi_rd(`OFF_CHANGE_FLAGS);
      check("flags after reset", rd, 32'h0000_0001);
      axi_rd(`OFF_OWN_STATE);
      check("own after reset", rd, OWN_RST & IMPL);
      $display("Test mid-run reset done");
      finish_test();
   end
endmodule // testbench
